/* File: core/pls_pkg.sv */
// Purpose: Shared constants and state type for the probe latch status flags.
// Assumes: APB register access, one clock, probe inputs already synchronous.
// Notes: Register offsets are word indices; byte address is four times the index.
package pls_pkg;

  // Word indices and the derived byte addresses
  localparam logic [31:0] IDX_FUNC_PRI = 32'h0000_60b8;
  localparam logic [31:0] IDX_STATUS_PRI = 32'h0000_60b9;
  localparam logic [31:0] IDX_FUNC_SEC = 32'h0000_2de8;
  localparam logic [31:0] IDX_STATUS_SEC = 32'h0000_2de9;
  localparam logic [31:0] ADDR_FUNC_PRI = IDX_FUNC_PRI << 2;
  localparam logic [31:0] ADDR_STATUS_PRI = IDX_STATUS_PRI << 2;
  localparam logic [31:0] ADDR_FUNC_SEC = IDX_FUNC_SEC << 2;
  localparam logic [31:0] ADDR_STATUS_SEC = IDX_STATUS_SEC << 2;

  localparam logic [15:0] FUNC_RESET = 16'h0000;
  localparam int NPROBE = 3;

  // Per probe: which word pair it lives in (0 primary, 1 secondary)
  localparam int PROBE_SEC [NPROBE] = '{0, 0, 1};
  // Function word bit positions per probe
  localparam int FN_EN [NPROBE] = '{0, 8, 0};
  localparam int FN_CONT [NPROBE] = '{1, 9, 1};
  localparam int FN_SAMP_R [NPROBE] = '{4, 12, 4};
  localparam int FN_SAMP_F [NPROBE] = '{5, 13, 5};
  localparam int FN_CLR_R [NPROBE] = '{4, 9, 4};
  localparam int FN_CLR_F [NPROBE] = '{5, 10, 5};
  // Status word bit positions per probe
  localparam int ST_EN [NPROBE] = '{0, 8, 0};
  localparam int ST_STORED_R [NPROBE] = '{1, 9, 1};
  localparam int ST_STORED_F [NPROBE] = '{2, 10, 2};
  localparam int ST_TOG_R [NPROBE] = '{6, 14, 6};
  localparam int ST_TOG_F [NPROBE] = '{7, 15, 7};

  typedef enum logic [0:0] {
    PH_IDLE,
    PH_ANSWER
  } pls_phase_t;

  typedef struct packed {
    pls_phase_t ph;
    logic [15:0] func_pri;
    logic [15:0] func_sec;
    logic [2:0] stored_r;
    logic [2:0] stored_f;
    logic [2:0] tog_r;
    logic [2:0] tog_f;
    logic [2:0] prev_in;
    logic [2:0] cap_r;
    logic [2:0] cap_f;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [15:0] stat_pri;
    logic [15:0] stat_sec;
  } pls_state_t;

  localparam pls_state_t STATE_RESET = '{
    ph: PH_IDLE,
    func_pri: FUNC_RESET,
    func_sec: FUNC_RESET,
    prdata: 32'h0000_0000,
    stat_pri: 16'h0000,
    stat_sec: 16'h0000,
    default: '0
  };

endpackage

/* File: core/pls_probe_status.sv */
// Purpose: Enable, stored and toggle status flags for three position latch probes.
// Assumes: APB slave with one wait state; probe inputs synchronous to i_clk.
// Notes: Position and time stamp holding registers sit outside and load on the capture pulses.
// Notes on behaviour
// - Primary status bit 0 mirrors probe 1 enable.
// - Primary bit 1 sets when probe 1 rising latch is stored.
// - Writing 0 to primary function bit 4 clears probe 1 rising flag.
// - Primary bit 2 sets when probe 1 falling latch is stored.
// - Writing 0 to primary function bit 5 clears probe 1 falling flag.
// - Reserved status bits read as zero; host writes zero there.
// - Continuous mode: primary bit 6 inverts on each probe 1 rising latch.
// - Continuous mode: primary bit 7 inverts on each probe 1 falling latch.
// - Primary status bit 8 mirrors probe 2 enable.
// - Primary bit 9 sets when probe 2 rising latch is stored.
// - Writing 0 to primary function bit 9 clears probe 2 rising flag.
// - Primary bit 10 sets when probe 2 falling latch is stored.
// - Writing 0 to primary function bit 10 clears probe 2 falling flag.
// - Continuous mode: primary bit 14 inverts on each probe 2 rising latch.
// - Continuous mode: primary bit 15 inverts on each probe 2 falling latch.
// - Secondary status bit 0 mirrors probe 3 enable.
// - Secondary bit 1 sets on probe 3 rising latch, clears by function bit 4.
// - Secondary bit 2 sets on probe 3 falling latch, clears by function bit 5.
// - Continuous mode: secondary bit 6 inverts on each probe 3 rising latch.
// - Continuous mode: secondary bit 7 inverts on each probe 3 falling latch.
// - Mode bit 0 selects single trigger, 1 selects continuous trigger.
// - Disabling a probe clears its enable and both stored flags.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pls_probe_status
  import pls_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_probe_input_one,
  input wire logic i_probe_input_two,
  input wire logic i_probe_input_three,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output logic [15:0] o_status_primary,
  output logic [15:0] o_status_secondary,
  output logic [2:0] o_capture_rise,
  output logic [2:0] o_capture_fall
);

  pls_state_t st_ff;
  pls_state_t nxt_st;
  logic [2:0] fire_r;
  logic [2:0] fire_f;
  logic bus_wr;
  logic wr_func_pri;
  logic wr_func_sec;
  logic wr_status;
  logic [2:0] probe_in;

  assign probe_in = {i_probe_input_three, i_probe_input_two, i_probe_input_one};

  function automatic logic [15:0] func_of(input pls_state_t s, input int p);
    func_of = (PROBE_SEC[p] == 1) ? s.func_sec : s.func_pri;
  endfunction

  // Builds one status word; reserved positions stay zero
  function automatic logic [15:0] status_word(input pls_state_t s, input int sec);
    logic [15:0] w;
    logic [15:0] f;
    w = 16'h0000;
    for (int p = 0; p < NPROBE; p++) begin
      f = func_of(s, p);
      if (PROBE_SEC[p] == sec) begin
        w[ST_EN[p]] = f[FN_EN[p]];
        w[ST_STORED_R[p]] = s.stored_r[p];
        w[ST_STORED_F[p]] = s.stored_f[p];
        w[ST_TOG_R[p]] = s.tog_r[p];
        w[ST_TOG_F[p]] = s.tog_f[p];
      end
    end
    status_word = w;
  endfunction

  function automatic logic addr_mapped(input logic [31:0] a);
    addr_mapped = (a == ADDR_FUNC_PRI) || (a == ADDR_STATUS_PRI) ||
                  (a == ADDR_FUNC_SEC) || (a == ADDR_STATUS_SEC);
  endfunction

  always_comb begin
    logic [15:0] f;
    logic [15:0] wd;
    logic wr_mine;
    logic edge_r;
    logic edge_f;
    logic cont;
    f = 16'h0000;
    wd = 16'h0000;
    wr_mine = 1'b0;
    edge_r = 1'b0;
    edge_f = 1'b0;
    cont = 1'b0;
    nxt_st = st_ff;
    nxt_st.cap_r = 3'b000;
    nxt_st.cap_f = 3'b000;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    nxt_st.ph = PH_IDLE;
    fire_r = 3'b000;
    fire_f = 3'b000;

    // One wait state: pready rises in the second access cycle
    bus_wr = i_psel && i_penable && st_ff.pready && i_pwrite;
    wr_func_pri = bus_wr && (i_paddr == ADDR_FUNC_PRI);
    wr_func_sec = bus_wr && (i_paddr == ADDR_FUNC_SEC);
    wr_status = bus_wr && ((i_paddr == ADDR_STATUS_PRI) || (i_paddr == ADDR_STATUS_SEC));
    if (i_psel && i_penable && !st_ff.pready) begin
      nxt_st.ph = PH_ANSWER;
      nxt_st.pready = 1'b1;
      nxt_st.pslverr = !addr_mapped(i_paddr);
      case (i_paddr)
        ADDR_FUNC_PRI: nxt_st.prdata = {16'h0000, st_ff.func_pri};
        ADDR_FUNC_SEC: nxt_st.prdata = {16'h0000, st_ff.func_sec};
        ADDR_STATUS_PRI: nxt_st.prdata = {16'h0000, status_word(st_ff, 0)};
        ADDR_STATUS_SEC: nxt_st.prdata = {16'h0000, status_word(st_ff, 1)};
        default: nxt_st.prdata = 32'h0000_0000;
      endcase
    end

    // Status words are read only, so a write there lands nowhere
    if (wr_func_pri) begin
      nxt_st.func_pri = i_pwdata[15:0];
    end
    if (wr_func_sec) begin
      nxt_st.func_sec = i_pwdata[15:0];
    end

    for (int p = 0; p < NPROBE; p++) begin
      f = func_of(st_ff, p);
      wd = i_pwdata[15:0];
      wr_mine = (PROBE_SEC[p] == 1) ? wr_func_sec : wr_func_pri;
      cont = f[FN_CONT[p]];
      // No glitch filter: a clean input is the far side's job
      edge_r = probe_in[p] && !st_ff.prev_in[p];
      edge_f = !probe_in[p] && st_ff.prev_in[p];
      // Single mode holds the first latch until the flag is cleared
      fire_r[p] = f[FN_EN[p]] && f[FN_SAMP_R[p]] && edge_r &&
                  (cont || !st_ff.stored_r[p]);
      fire_f[p] = f[FN_EN[p]] && f[FN_SAMP_F[p]] && edge_f &&
                  (cont || !st_ff.stored_f[p]);
      if (wr_mine && (!wd[FN_CLR_R[p]] || !wd[FN_EN[p]])) begin
        nxt_st.stored_r[p] = 1'b0;
      end
      if (wr_mine && (!wd[FN_CLR_F[p]] || !wd[FN_EN[p]])) begin
        nxt_st.stored_f[p] = 1'b0;
      end
      // A latch in the same cycle as a clear wins
      if (fire_r[p]) begin
        nxt_st.stored_r[p] = 1'b1;
        nxt_st.cap_r[p] = 1'b1;
        if (cont) begin
          nxt_st.tog_r[p] = ~st_ff.tog_r[p];
        end
      end
      if (fire_f[p]) begin
        nxt_st.stored_f[p] = 1'b1;
        nxt_st.cap_f[p] = 1'b1;
        if (cont) begin
          nxt_st.tog_f[p] = ~st_ff.tog_f[p];
        end
      end
    end
    nxt_st.prev_in = probe_in;
    nxt_st.stat_pri = status_word(nxt_st, 0);
    nxt_st.stat_sec = status_word(nxt_st, 1);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_ff <= STATE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_pready = st_ff.pready;
  assign o_prdata = st_ff.prdata;
  assign o_pslverr = st_ff.pslverr;
  assign o_status_primary = st_ff.stat_pri;
  assign o_status_secondary = st_ff.stat_sec;
  assign o_capture_rise = st_ff.cap_r;
  assign o_capture_fall = st_ff.cap_f;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_rise1_fire;
    fire_r[0] && o_status_primary[ST_TOG_R[0]] == 1'b0;
  endsequence

  sequence s_rise1_toggled;
    o_status_primary[ST_TOG_R[0]] && o_capture_rise[0];
  endsequence

  // Probe 3 toggle steps: a latch in continuous mode, then a flip together with its pulse
  sequence s_rise3_cont;
    fire_r[2] && st_ff.func_sec[FN_CONT[2]];
  endsequence

  sequence s_rise3_flipped;
    o_status_secondary[6] != $past(o_status_secondary[6]) && o_capture_rise[2];
  endsequence

  sequence s_fall3_cont;
    fire_f[2] && st_ff.func_sec[FN_CONT[2]];
  endsequence

  sequence s_fall3_flipped;
    o_status_secondary[7] != $past(o_status_secondary[7]) && o_capture_fall[2];
  endsequence

  a_enable_one_mirror: assert property (
    wr_func_pri |=> o_status_primary[0] == $past(i_pwdata[0]))
    else $error("probe 1 enable status does not follow function write");

  a_rise_one_set: assert property (
    fire_r[0] |=> o_status_primary[1] && o_capture_rise[0])
    else $error("probe 1 rising stored flag or capture missing");

  a_rise_one_clear: assert property (
    wr_func_pri && !i_pwdata[4] && !fire_r[0] |=> !o_status_primary[1])
    else $error("probe 1 rising stored flag not cleared");

  a_fall_one_set: assert property (
    fire_f[0] |=> o_status_primary[2] && o_capture_fall[0])
    else $error("probe 1 falling stored flag or capture missing");

  a_fall_one_clear: assert property (
    wr_func_pri && !i_pwdata[5] && !fire_f[0] |=> !o_status_primary[2])
    else $error("probe 1 falling stored flag not cleared");

  a_reserved_zero: assert property (
    o_status_primary[5:3] == 3'b000 && o_status_primary[13:11] == 3'b000 &&
    o_status_secondary[5:3] == 3'b000 && o_status_secondary[15:8] == 8'h00)
    else $error("reserved status bits not zero");

  a_toggle_rise_one: assert property (
    s_rise1_fire and st_ff.func_pri[1] |=> s_rise1_toggled)
    else $error("probe 1 rising toggle did not invert");

  a_toggle_fall_one: assert property (
    fire_f[0] && st_ff.func_pri[1] |=>
      o_status_primary[7] != $past(o_status_primary[7]))
    else $error("probe 1 falling toggle did not invert");

  a_enable_two_mirror: assert property (
    wr_func_pri |=> o_status_primary[8] == $past(i_pwdata[8]))
    else $error("probe 2 enable status does not follow function write");

  a_rise_two_set: assert property (
    fire_r[1] |=> o_status_primary[9] && o_capture_rise[1] ##1 !o_capture_rise[1])
    else $error("probe 2 rising stored flag or capture pulse wrong");

  a_rise_two_clear: assert property (
    wr_func_pri && !i_pwdata[9] && !fire_r[1] |=> !o_status_primary[9])
    else $error("probe 2 rising stored flag not cleared");

  a_fall_two_clear: assert property (
    wr_func_pri && !i_pwdata[10] && !fire_f[1] |=> !o_status_primary[10])
    else $error("probe 2 falling stored flag not cleared");

  a_toggle_rise_two: assert property (
    fire_r[1] && st_ff.func_pri[9] |=>
      o_status_primary[14] != $past(o_status_primary[14]))
    else $error("probe 2 rising toggle did not invert");

  a_enable_three_mirror: assert property (
    wr_func_sec |=> o_status_secondary[0] == $past(i_pwdata[0]))
    else $error("probe 3 enable status does not follow function write");

  a_rise_three_set: assert property (
    fire_r[2] |=> o_status_secondary[1])
    else $error("probe 3 rising stored flag not set");

  a_single_no_relatch: assert property (
    o_status_primary[1] && !st_ff.func_pri[1] && !wr_func_pri |-> !fire_r[0])
    else $error("single trigger mode latched twice");

  a_disable_clears: assert property (
    wr_func_sec && !i_pwdata[0] && !fire_r[2] && !fire_f[2] |=>
      o_status_secondary[2:0] == 3'b000)
    else $error("disabling probe 3 left status bits set");

  a_status_write_inert: assert property (
    wr_status && fire_r == 3'b000 && fire_f == 3'b000 |=> $stable(o_status_primary) &&
      $stable(o_status_secondary))
    else $error("status write changed a status bit");

  a_apb_wait_state: assert property (
    i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("apb answer not a single cycle after one wait state");

  a_fall_two_set: assert property (
    fire_f[1] |=> o_status_primary[10] && o_capture_fall[1])
    else $error("probe 2 falling stored flag or capture missing");

  a_toggle_fall_two: assert property (
    fire_f[1] && st_ff.func_pri[9] |=>
      o_status_primary[15] != $past(o_status_primary[15]))
    else $error("probe 2 falling toggle did not invert");

  a_rise_three_clear: assert property (
    wr_func_sec && !i_pwdata[4] && !fire_r[2] |=> !o_status_secondary[1])
    else $error("probe 3 rising stored flag not cleared");

  a_fall_three_set: assert property (
    fire_f[2] |=> o_status_secondary[2] && o_capture_fall[2])
    else $error("probe 3 falling stored flag or capture missing");

  a_fall_three_clear: assert property (
    wr_func_sec && !i_pwdata[5] && !fire_f[2] |=> !o_status_secondary[2])
    else $error("probe 3 falling stored flag not cleared");

  a_toggle_rise_three: assert property (
    s_rise3_cont |=> s_rise3_flipped)
    else $error("probe 3 rising toggle did not invert");

  a_toggle_fall_three: assert property (
    s_fall3_cont |=> s_fall3_flipped)
    else $error("probe 3 falling toggle did not invert");

  // Single mode must leave both toggles where they were
  a_single_no_toggle: assert property (
    fire_r[0] && !st_ff.func_pri[1] |=> $stable(o_status_primary[6]))
    else $error("probe 1 rising toggle moved in single mode");

  a_single_hold_fall: assert property (
    fire_f[0] && !st_ff.func_pri[1] |=> $stable(o_status_primary[7]))
    else $error("probe 1 falling toggle moved in single mode");

  a_single_fall_relatch: assert property (
    o_status_primary[2] && !st_ff.func_pri[1] |-> !fire_f[0])
    else $error("single trigger mode latched a falling edge twice");

  a_disable_one_clears: assert property (
    wr_func_pri && !i_pwdata[0] && !fire_r[0] && !fire_f[0] |=>
      o_status_primary[2:0] == 3'b000)
    else $error("disabling probe 1 left status bits set");

  a_disable_two_clears: assert property (
    wr_func_pri && !i_pwdata[8] && !fire_r[1] && !fire_f[1] |=>
      o_status_primary[10:8] == 3'b000)
    else $error("disabling probe 2 left status bits set");

  a_disabled_ignored: assert property (
    !st_ff.func_sec[0] |-> !fire_r[2] && !fire_f[2])
    else $error("disabled probe 3 still latched");

  a_no_sample_ignored: assert property (
    !st_ff.func_pri[4] |-> !fire_r[0])
    else $error("probe 1 latched a rising edge while not sampling it");

  a_rise_one_pulse: assert property (
    o_capture_rise[0] |=> !o_capture_rise[0])
    else $error("probe 1 rising capture pulse longer than one cycle");

  a_fall_one_pulse: assert property (
    o_capture_fall[0] |=> !o_capture_fall[0])
    else $error("probe 1 falling capture pulse longer than one cycle");

  // A status write is accepted quietly, not flagged as an error
  a_status_write_ok: assert property (
    wr_status |-> !o_pslverr)
    else $error("status write answered with an error");

endmodule

`default_nettype wire

/* File: verif/pls_host_model.sv */
// Purpose: APB host that writes and reads the probe words on request.
// Assumes: One request at a time; i_go is seen only while the bus is idle.
// Notes: Released address and data lines show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none

module pls_host_model
  import pls_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_go,
  input wire logic i_wr,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [31:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic o_done,
  output logic [31:0] o_rdata,
  output logic o_err
);
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      o_done <= 1'b0;
      o_pwrite <= 1'b0;
      o_paddr <= 32'h0000_0000;
      o_pwdata <= 32'h0000_0000;
      o_rdata <= 32'h0000_0000;
      o_err <= 1'b0;
    end else if (o_done) begin
      o_done <= 1'b0;
    end else if (!o_psel && i_go) begin
      o_psel <= 1'b1;
      o_pwrite <= i_wr;
      o_paddr <= i_addr;
      // Reserved status bits are always sent as zero
      o_pwdata <= (i_addr == ADDR_STATUS_PRI) ? (i_wdata & 32'h0000_c7c7) :
        (i_addr == ADDR_STATUS_SEC) ? (i_wdata & 32'h0000_00c7) : i_wdata;
    end else if (o_psel && !o_penable) begin
      o_penable <= 1'b1;
    end else if (o_penable && i_pready) begin
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      o_paddr <= ~o_paddr;
      o_pwdata <= ~o_pwdata;
      o_rdata <= i_prdata;
      o_err <= i_pslverr;
      o_done <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb_pls_probe_status.sv */
// Purpose: Self-checking bench for the probe latch status flags.
// Assumes: Host model drives APB; bench drives the probe inputs.
// Notes: Probe hold time is shortened; the block has no input filter.
`timescale 1ns/1ps
`default_nettype none

module tb_pls_probe_status
  import pls_pkg::*;
;
  localparam int HOLD = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic [31:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [2:0] prb = '0;
  logic psel, penable, pwrite, pready, pslverr, done, err;
  logic [31:0] paddr, pwdata, prdata, rdata;
  logic [15:0] stp, sts;
  logic [2:0] cr, cf;
  int err_total = 0;
  int checks_done = 0;

  always #5 clk = ~clk;

  pls_probe_status pls_probe_status_inst (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_probe_input_one(prb[0]), .i_probe_input_two(prb[1]), .i_probe_input_three(prb[2]),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .o_status_primary(stp),
    .o_status_secondary(sts), .o_capture_rise(cr), .o_capture_fall(cf));

  pls_host_model pls_host_model_inst (.i_clk(clk), .i_sys_rst(rst), .i_go(go), .i_wr(wr),
    .i_addr(addr), .i_wdata(wdata), .i_pready(pready), .i_prdata(prdata),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata), .o_done(done), .o_rdata(rdata), .o_err(err));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= {16'h0000, d};
    @(posedge clk);
    go <= 1'b0;
    // No fixed answer time is assumed; a hang is left to the watchdog
    while (done !== 1'b1) begin
      @(negedge clk);
    end
  endtask

  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(rdata, {16'h0000, e});
  endtask

  // Status updates on the write edge itself; two negedges give margin
  task automatic st(input logic s, input logic [15:0] e);
    repeat (2) @(negedge clk);
    chk({16'h0000, s ? sts : stp}, {16'h0000, e});
  endtask

  task automatic trig(input int p, input logic v, input logic [2:0] e);
    @(posedge clk);
    prb[p] <= v;
    repeat (2) @(negedge clk);
    chk({26'h0, cr, cf}, v ? {26'h0, e, 3'b000} : {26'h0, 3'b000, e});
    repeat (HOLD) @(posedge clk);
  endtask

  task automatic t_reset();
    rd(ADDR_STATUS_PRI, 16'h0000);
    rd(ADDR_STATUS_SEC, 16'h0000);
    rd(ADDR_FUNC_PRI, FUNC_RESET);
    bus(1'b1, 32'h0000_0100, 16'h1234);
    chk({31'h0, err}, 32'h0000_0001);
    rd(32'h0000_0100, 16'h0000);
    chk({31'h0, err}, 32'h0000_0001);
  endtask

  task automatic t_single();
    bus(1'b1, ADDR_FUNC_PRI, 16'h0031);
    st(1'b0, 16'h0001);
    rd(ADDR_FUNC_PRI, 16'h0031);
    trig(0, 1'b1, 3'b001);
    st(1'b0, 16'h0003);
    trig(0, 1'b0, 3'b001);
    st(1'b0, 16'h0007);
    trig(0, 1'b1, 3'b000);
    bus(1'b1, ADDR_FUNC_PRI, 16'h0021);
    st(1'b0, 16'h0005);
    bus(1'b1, ADDR_FUNC_PRI, 16'h0001);
    st(1'b0, 16'h0001);
    bus(1'b1, ADDR_STATUS_PRI, 16'hffff);
    chk({31'h0, err}, 32'h0000_0000);
    st(1'b0, 16'h0001);
  endtask

  task automatic t_cont();
    bus(1'b1, ADDR_FUNC_PRI, 16'h0033);
    trig(0, 1'b0, 3'b001);
    st(1'b0, 16'h0085);
    trig(0, 1'b1, 3'b001);
    st(1'b0, 16'h00c7);
    trig(0, 1'b0, 3'b001);
    st(1'b0, 16'h0047);
    trig(0, 1'b1, 3'b001);
    st(1'b0, 16'h0007);
    rd(ADDR_STATUS_PRI, 16'h0007);
    bus(1'b1, ADDR_FUNC_PRI, 16'h0000);
    st(1'b0, 16'h0000);
  endtask

  task automatic t_probe2();
    bus(1'b1, ADDR_FUNC_PRI, 16'h3300);
    st(1'b0, 16'h0100);
    trig(1, 1'b1, 3'b010);
    st(1'b0, 16'h4300);
    trig(1, 1'b0, 3'b010);
    st(1'b0, 16'hc700);
    bus(1'b1, ADDR_FUNC_PRI, 16'h3500);
    st(1'b0, 16'hc500);
    bus(1'b1, ADDR_FUNC_PRI, 16'h3300);
    st(1'b0, 16'hc100);
  endtask

  task automatic t_probe3();
    bus(1'b1, ADDR_FUNC_SEC, 16'h0033);
    st(1'b1, 16'h0001);
    trig(2, 1'b1, 3'b100);
    st(1'b1, 16'h0043);
    trig(2, 1'b0, 3'b100);
    st(1'b1, 16'h00c7);
    bus(1'b1, ADDR_FUNC_SEC, 16'h0023);
    st(1'b1, 16'h00c5);
    bus(1'b1, ADDR_FUNC_SEC, 16'h0003);
    st(1'b1, 16'h00c1);
    bus(1'b1, ADDR_STATUS_SEC, 16'hffff);
    chk({31'h0, err}, 32'h0000_0000);
    st(1'b1, 16'h00c1);
    rd(ADDR_STATUS_SEC, 16'h00c1);
  endtask

  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_single();
    t_cont();
    t_probe2();
    t_probe3();
    close_out();
  end

  // Whole run is a few hundred cycles; this leaves wide margin
  initial begin
    #100_000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
